// ### isam_pkg.sv
// Constants, register map and state encoding for the I2C slave address matcher.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package isam_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OWN = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_RXBUF = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_IEN = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;

  // ==========================================================================
  // Control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_GC_EN = 1;
  localparam int CTRL_HOLD_EN = 2;
  localparam int CTRL_TEN = 3;
  localparam int CTRL_ACKV = 4;
  localparam int CTRL_REL = 5;

  // ==========================================================================
  // Status and interrupt enable field positions
  localparam int SB_ADDR = 0;
  localparam int SB_GC = 1;
  localparam int SB_RX = 2;
  localparam int SB_STOP = 3;

  // ==========================================================================
  // Values after reset
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [9:0] OWN_RST = 10'h000;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [3:0] STAT_RST = 4'h0;

  // ==========================================================================
  // Bus protocol values and bit counts
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [4:0] TEN_HDR = 5'h1E;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Link state, Gray coded along idle, address, ack, data
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_DATA = 3'b010,
    ST_ADDR2 = 3'b110,
    ST_SKIP = 3'b100
  } isam_state_t;

endpackage

// ### isam_sync.sv
// Two-flop synchroniser for the bus pins.
// Assumes inputs are asynchronous to clk; only q may be read by other logic.
`timescale 1ns/1ps
module isam_sync #(
  parameter int W = 2
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// ### isam_top.sv
// I2C slave address recognition with general call, address mask and address hold.
// Assumes SCL/SDA arrive asynchronously and are resolved as open drain by the bench.
//
// Functional notes
// - Received address 0x00 is the general call, addressing every slave.
// - With general call enabled, general call is acked regardless of own address; with address hold on, the code acks only if CTRL_ACKV is clear at release.
// - With general call enabled, all-zero address with write bit clear raises an interrupt event.
// - Ten-bit mode: general call leaves update-address flag clear; next byte is data.
// - Address hold enabled: SCL held low after eighth falling edge until released.
// - A zero mask bit makes that received address bit a don't-care.
// - Mask resets to all ones on every reset.
// - Seven-bit mode: mask applies to received address bits 7 to 1.
// - Ten-bit mode: mask applies to low byte bits 7 to 0 only.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module isam_top
  import isam_pkg::*;
(
  input wire logic aclk, // System clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic scl_i, // SCL level on the bus
  output logic scl_o, // SCL drive level, always low
  output logic scl_oe, // SCL pulled low while high
  input wire logic sda_i, // SDA level on the bus
  output logic sda_o, // SDA drive level, always low
  output logic sda_oe, // SDA pulled low while high
  output logic irq // Level interrupt
);

  // ==========================================================================
  // Helpers
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    masked_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == OFF_CTRL) || (a == OFF_OWN) || (a == OFF_MASK) || (a == OFF_RXBUF) ||
                (a == OFF_STAT) || (a == OFF_IEN) || (a == OFF_STATE);
  endfunction

  // ==========================================================================
  // Pin sampling and bus events
  logic [1:0] pin_s;
  logic scl_s, sda_s, scl_d_r, sda_d_r;
  logic ev_rise, ev_fall, ev_start, ev_stop, byte_done, gc_now, hi_now;

  isam_sync #(.W(2)) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({scl_i, sda_i}),
    .q(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  assign ev_rise = scl_s & ~scl_d_r;
  assign ev_fall = ~scl_s & scl_d_r;
  assign ev_start = scl_s & scl_d_r & ~sda_s & sda_d_r;
  assign ev_stop = scl_s & scl_d_r & sda_s & ~sda_d_r;

  // ==========================================================================
  // Register state
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [9:0] own_r, own_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [3:0] ien_r, ien_nxt;
  logic [3:0] status_r, status_nxt;
  logic irq_r, irq_nxt;
  logic rel_pulse;
  logic [3:0] ev_set;

  // ==========================================================================
  // Link state
  isam_state_t st_r, st_nxt, dest_r, dest_nxt, dest_c;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sr_r, sr_nxt, rxbuf_r, rxbuf_nxt;
  logic hold_r, hold_nxt, sda_oe_r, sda_oe_nxt, upd_r, upd_nxt, hit_c, zero_r;

  assign gc_now = (sr_r == GC_ADDR) && ctrl_r[CTRL_GC_EN];
  assign hi_now = sr_r[7:1] == {TEN_HDR, own_r[9:8]};
  assign byte_done = ev_fall && (cnt_r == CNT_BYTE);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sr_nxt = sr_r;
    dest_nxt = dest_r;
    hold_nxt = hold_r;
    sda_oe_nxt = sda_oe_r;
    upd_nxt = upd_r;
    rxbuf_nxt = rxbuf_r;
    ev_set = 4'h0;
    hit_c = 1'b0;
    dest_c = ST_DATA;
    if (!ctrl_r[CTRL_EN] || ev_stop) begin
      ev_set[SB_STOP] = ev_stop && (st_r != ST_IDLE);
      st_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
      hold_nxt = 1'b0;
    end else if (ev_start) begin
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
      hold_nxt = 1'b0;
      upd_nxt = 1'b0;
    end else if (hold_r) begin
      if (rel_pulse) begin
        hold_nxt = 1'b0;
        sda_oe_nxt = ~ctrl_r[CTRL_ACKV];
        upd_nxt = 1'b0;
      end
    end else begin
      unique case (st_r)
        ST_IDLE, ST_SKIP: begin
        end
        ST_ADDR, ST_ADDR2, ST_DATA: begin
          if (ev_rise && (cnt_r < CNT_BYTE)) begin
            sr_nxt = {sr_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            if (st_r == ST_DATA) begin
              hit_c = 1'b1;
              rxbuf_nxt = sr_r;
              ev_set[SB_RX] = 1'b1;
            end else if (st_r == ST_ADDR && gc_now) begin
              hit_c = 1'b1;
              ev_set[SB_GC] = 1'b1;
            end else if (st_r == ST_ADDR && ctrl_r[CTRL_TEN]) begin
              hit_c = hi_now;
              dest_c = sr_r[0] ? ST_SKIP : ST_ADDR2;
              upd_nxt = hi_now;
            end else if (st_r == ST_ADDR) begin
              hit_c = masked_eq({sr_r[7:1], 1'b0}, {own_r[6:0], 1'b0}, {mask_r[7:1], 1'b0});
              dest_c = sr_r[0] ? ST_SKIP : ST_DATA;
              ev_set[SB_ADDR] = hit_c;
            end else begin
              hit_c = masked_eq(sr_r, own_r[7:0], mask_r);
              upd_nxt = hit_c;
              ev_set[SB_ADDR] = hit_c;
            end
            dest_nxt = dest_c;
            if (!hit_c) begin
              st_nxt = ST_SKIP;
            end else begin
              st_nxt = ST_ACK;
              if (st_r == ST_DATA) begin
                sda_oe_nxt = ~ctrl_r[CTRL_ACKV];
              end else if (ctrl_r[CTRL_HOLD_EN]) begin
                hold_nxt = 1'b1;
              end else begin
                sda_oe_nxt = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (ev_rise) begin
            cnt_nxt = CNT_ACK;
          end else if (ev_fall && (cnt_r == CNT_ACK)) begin
            cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
            st_nxt = dest_r;
          end
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      dest_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      rxbuf_r <= 8'h00;
      hold_r <= 1'b0;
      sda_oe_r <= 1'b0;
      upd_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      zero_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dest_r <= dest_nxt;
      cnt_r <= cnt_nxt;
      sr_r <= sr_nxt;
      rxbuf_r <= rxbuf_nxt;
      hold_r <= hold_nxt;
      sda_oe_r <= sda_oe_nxt;
      upd_r <= upd_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      zero_r <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave and registers
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, rd_mux;
  logic wr_go, rd_go;

  assign wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign rd_go = s_axi_arvalid && arready_r;
  assign rel_pulse = wr_go && (awaddr_r == OFF_CTRL) && wstrb_r[0] && wdata_r[CTRL_REL];

  always_comb begin
    unique case (s_axi_araddr)
      OFF_CTRL: rd_mux = {27'h0, ctrl_r};
      OFF_OWN: rd_mux = {22'h0, own_r};
      OFF_MASK: rd_mux = {24'h0, mask_r};
      OFF_RXBUF: rd_mux = {24'h0, rxbuf_r};
      OFF_STAT: rd_mux = {28'h0, status_r};
      OFF_IEN: rd_mux = {28'h0, ien_r};
      OFF_STATE: rd_mux = {27'h0, hold_r, upd_r, st_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    own_nxt = own_r;
    mask_nxt = mask_r;
    ien_nxt = ien_r;
    status_nxt = status_r;
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = reg_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      if (wstrb_r[0]) begin
        unique case (awaddr_r)
          OFF_CTRL: ctrl_nxt = wdata_r[4:0];
          OFF_OWN: own_nxt[7:0] = wdata_r[7:0];
          OFF_MASK: mask_nxt = wdata_r[7:0];
          OFF_IEN: ien_nxt = wdata_r[3:0];
          default: begin
          end
        endcase
      end
      if (wstrb_r[1] && (awaddr_r == OFF_OWN)) begin
        own_nxt[9:8] = wdata_r[9:8];
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_mux;
      rresp_nxt = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == OFF_STAT) begin
        status_nxt = 4'h0;
      end
    end
    status_nxt = status_nxt | ev_set;
    irq_nxt = |(status_nxt & ien_nxt);
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
      ctrl_r <= CTRL_RST;
      own_r <= OWN_RST;
      mask_r <= MASK_RST;
      ien_r <= IEN_RST;
      status_r <= STAT_RST;
      irq_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      own_r <= own_nxt;
      mask_r <= mask_nxt;
      ien_r <= ien_nxt;
      status_r <= status_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign scl_o = zero_r;
  assign scl_oe = hold_r;
  assign sda_o = zero_r;
  assign sda_oe = sda_oe_r;
  assign irq = irq_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic addr7_c, gc_ev_c;
  assign addr7_c = byte_done && ctrl_r[CTRL_EN] && (st_r == ST_ADDR) && !ctrl_r[CTRL_TEN] && !gc_now;
  assign gc_ev_c = byte_done && ctrl_r[CTRL_EN] && (st_r == ST_ADDR) && (sr_r == GC_ADDR) && ctrl_r[CTRL_GC_EN];

  a_mask_reset_ones: assert property ($rose(aresetn) |-> mask_r == MASK_RST)
    else $error("mask not all ones after reset");
  a_gc_auto_ack: assert property (gc_ev_c && !ctrl_r[CTRL_HOLD_EN] |=> sda_oe && st_r == ST_ACK)
    else $error("general call not acknowledged");
  a_gc_raises_event: assert property (gc_ev_c |=> status_r[SB_GC] && (irq || !ien_r[SB_GC]))
    else $error("general call event not flagged");
  a_gc_ten_no_upd: assert property (gc_ev_c && ctrl_r[CTRL_TEN] |=> !upd_r && dest_r == ST_DATA)
    else $error("general call set update flag or skipped data");
  a_hold_on_addr: assert property (gc_ev_c && ctrl_r[CTRL_HOLD_EN] |=> scl_oe && !sda_oe)
    else $error("clock not held after address");
  a_hold_until_rel: assert property (hold_r && !rel_pulse && ctrl_r[CTRL_EN] && !ev_stop && !ev_start |=> scl_oe)
    else $error("clock released without software");
  a_seven_mask_hit: assert property (addr7_c && masked_eq(sr_r, {own_r[6:0], 1'b0}, mask_r & 8'hFE)
    |=> st_r == ST_ACK && status_r[SB_ADDR])
    else $error("masked seven-bit address not matched");
  a_seven_mask_miss: assert property (addr7_c && !masked_eq(sr_r, {own_r[6:0], 1'b0}, mask_r & 8'hFE)
    |=> st_r == ST_SKIP && !sda_oe)
    else $error("unmasked mismatch accepted");
  a_ten_high_nomask: assert property (byte_done && ctrl_r[CTRL_EN] && st_r == ST_ADDR && ctrl_r[CTRL_TEN] && !gc_now
    && sr_r[7:1] != {TEN_HDR, own_r[9:8]} |=> st_r == ST_SKIP)
    else $error("high address byte matched through mask");
  a_ten_low_mask: assert property (byte_done && ctrl_r[CTRL_EN] && st_r == ST_ADDR2
    && masked_eq(sr_r, own_r[7:0], mask_r) |=> st_r == ST_ACK && upd_r)
    else $error("masked low address byte not matched");

  c_gc_acked: cover property (gc_ev_c ##1 sda_oe);
  c_ten_bit_match: cover property (st_r == ST_ADDR2 ##[1:1000] st_r == ST_DATA);
  c_data_irq: cover property (ev_set[SB_RX] ##2 irq);
  c_hold_release: cover property (hold_r ##1 rel_pulse ##1 !scl_oe);

endmodule

// ### isam_i2c_master.sv
// Behavioural I2C bus master that addresses the slave under test.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
module isam_i2c_master (
  input wire logic aclk, // Pacing clock
  input wire logic scl, // Resolved SCL wire
  input wire logic sda, // Resolved SDA wire
  output logic scl_oe, // High pulls SCL low
  output logic sda_oe // High pulls SDA low
);
  int errs = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // ==========================================================================
  // Bit timing, 8 clocks per SCL period
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Release SCL, then wait while a slave stretches it
  task automatic rise();
    int n;
    scl_oe <= 1'b0;
    n = 0;
    do begin
      w(1);
      n++;
    end while (!scl && n < 2000);
    if (!scl) errs++;
  endtask
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_oe <= !b;
    w(2);
    rise();
    w(1);
    r = sda;
    w(2);
    scl_oe <= 1'b1;
  endtask
  // ==========================================================================
  // Frame pieces
  task automatic send_start();
    sda_oe <= 1'b1;
    w(4);
    scl_oe <= 1'b1;
  endtask
  task automatic send_stop();
    w(2);
    sda_oe <= 1'b1;
    w(2);
    rise();
    w(4);
    sda_oe <= 1'b0;
    w(8);
  endtask
  // Most significant bit first, ninth bit released for the answer
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
endmodule

// ### isam_top_bench.sv
// Self-checking bench for the I2C slave address matcher.
// Assumes isam_pkg, isam_top and isam_i2c_master are compiled first.
`timescale 1ns/1ps
module isam_top_bench
  import isam_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [9:0] own;
    logic [7:0] mask;
    logic [7:0] adr;
    logic ack;
    logic [1:0] st;
  } isam_row_t;
  isam_row_t rows [8] = '{
    '{8'h03, 10'h055, 8'hFF, 8'hAA, 1'b1, 2'h1},
    '{8'h03, 10'h055, 8'hFF, 8'hAC, 1'b0, 2'h0},
    '{8'h03, 10'h055, 8'hFD, 8'hA8, 1'b1, 2'h1},
    '{8'h03, 10'h055, 8'h03, 8'h02, 1'b1, 2'h1},
    '{8'h03, 10'h055, 8'h03, 8'hFC, 1'b0, 2'h0},
    '{8'h03, 10'h055, 8'hFF, 8'h00, 1'b1, 2'h2},
    '{8'h03, 10'h055, 8'hFF, 8'hAB, 1'b1, 2'h1},
    '{8'h01, 10'h055, 8'hFF, 8'h00, 1'b0, 2'h0}};
  logic [7:0] ra [5] = '{OFF_CTRL, OFF_OWN, OFF_MASK, OFF_IEN, OFF_STAT};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, m_scl_oe, m_sda_oe, scl, sda, irq;
  int num_errors = 0;
  int cmp_count = 0;
  assign scl = (d_scl_oe ? d_scl_o : 1'b1) & !m_scl_oe;
  assign sda = (d_sda_oe ? d_sda_o : 1'b1) & !m_sda_oe;
  always #25 aclk = !aclk;
  isam_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl), .scl_o(d_scl_o),
    .scl_oe(d_scl_oe), .sda_i(sda), .sda_o(d_sda_o), .sda_oe(d_sda_oe), .irq(irq));
  isam_i2c_master u_mst (.aclk(aclk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  // ==========================================================================
  // Reporting
  task automatic test_done();
    num_errors += u_mst.errs;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
      num_errors++;
    end
  endtask
  // ==========================================================================
  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) begin
      $display("[ERR] %0t write answer missing", $time);
      num_errors++;
      test_done();
    end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) begin
      $display("[ERR] %0t read answer missing", $time);
      num_errors++;
      test_done();
    end
    @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    test_done();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic ack;
    int n;
    do_reset();
    chk(irq, 0, "irq after reset");
    foreach (ra[i]) begin
      rd(ra[i], d, r);
      chk(d, rv[i], "reset value");
    end
    wr(8'h1C, 32'h1, r);
    chk(r, RESP_SLVERR, "unmapped write");
    rd(8'h1C, d, r);
    chk(r, RESP_SLVERR, "unmapped read");
    $display("reset values done");
    foreach (rows[i]) begin
      wr(OFF_CTRL, 32'(rows[i].ctrl), r);
      wr(OFF_OWN, 32'(rows[i].own), r);
      wr(OFF_MASK, 32'(rows[i].mask), r);
      wr(OFF_IEN, 32'h3, r);
      rd(OFF_STAT, d, r);
      u_mst.send_start();
      u_mst.put_byte(rows[i].adr, ack);
      u_mst.send_stop();
      chk(ack, rows[i].ack, "address answer");
      chk(irq, |rows[i].st, "event interrupt");
      rd(OFF_STAT, d, r);
      chk(d[1:0], rows[i].st, "match status");
      $display("row %0d done", i);
    end
    wr(OFF_CTRL, 32'h0B, r);
    wr(OFF_IEN, 32'h4, r);
    rd(OFF_STAT, d, r);
    u_mst.send_start();
    u_mst.put_byte(8'h00, ack);
    chk(ack, 1, "ten-bit general call answer");
    chk(irq, 0, "masked event");
    repeat (8) @(posedge aclk);
    rd(OFF_STATE, d, r);
    chk(d[3:0], {1'b0, ST_DATA}, "general call state");
    u_mst.put_byte(8'h5A, ack);
    u_mst.send_stop();
    chk(irq, 1, "data interrupt");
    rd(OFF_RXBUF, d, r);
    chk(d, 32'h5A, "received byte");
    rd(OFF_STAT, d, r);
    chk(d[2:0], 3'b110, "general call status");
    repeat (3) @(posedge aclk);
    chk(irq, 0, "interrupt cleared");
    $display("general call data done");
    wr(OFF_CTRL, 32'h09, r);
    wr(OFF_OWN, 32'h2A5, r);
    wr(OFF_MASK, 32'h0F, r);
    u_mst.send_start();
    u_mst.put_byte(8'hF4, ack);
    chk(ack, 1, "high byte answer");
    u_mst.put_byte(8'h55, ack);
    u_mst.send_stop();
    chk(ack, 1, "masked low byte");
    wr(OFF_MASK, 32'h00, r);
    u_mst.send_start();
    u_mst.put_byte(8'hF6, ack);
    u_mst.send_stop();
    chk(ack, 0, "high byte unmasked");
    $display("ten-bit mask done");
    wr(OFF_OWN, 32'h055, r);
    wr(OFF_MASK, 32'hFF, r);
    for (int v = 0; v < 2; v++) begin
      wr(OFF_CTRL, 32'h07 | (v << 4), r);
      u_mst.send_start();
      fork
        u_mst.put_byte(8'h00, ack);
        begin
          for (n = 0; n < 400 && !d_scl_oe; n++) @(posedge aclk);
          if (n == 400) begin
            $display("[ERR] %0t clock hold missing", $time);
            num_errors++;
            test_done();
          end
          repeat (20) @(posedge aclk);
          chk(scl, 0, "clock held");
          wr(OFF_CTRL, 32'h27 | (v << 4), r);
        end
      join
      u_mst.send_stop();
      chk(ack, v == 0, "answer after release");
    end
    $display("address hold done");
    wr(OFF_MASK, 32'h00, r);
    do_reset();
    rd(OFF_MASK, d, r);
    chk(d, 32'hFF, "mask after reset");
    $display("second reset done");
    test_done();
  end
endmodule
